// ===== bench/slave_model.sv
`timescale 1ns/1ps

// ========
// receiving slave: one bit per trailing clock edge, no framing
module slave_model (
    input wire logic sck,
    input wire logic sd,
    input wire logic pol
);
    logic bits[$];
    always @(sck) begin
        if (sck === pol) begin
            bits.push_back(sd);
        end
    end
endmodule : slave_model

// ===== bench/sync_tx_monitor.sv
`timescale 1ns/1ps

// ========
// pin and holding register checks
module sync_tx_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic holdWrite,
    input wire logic clockPolaritySelect,
    input wire logic transmitEnable,
    input wire logic singleReceiveEnable,
    input wire logic continuousReceiveEnable,
    input wire logic serialDataPinOut,
    input wire logic serialDataPinOe,
    input wire logic serialClockPinOut,
    input wire logic serialClockPinOe,
    input wire logic transmitIrqFlag,
    input wire logic holdingFull,
    input wire logic writeIgnored
);
    wire pol = clockPolaritySelect;
    wire sck = serialClockPinOut;
    wire sd = serialDataPinOut;
    wire txOk = transmitEnable && !singleReceiveEnable && !continuousReceiveEnable;
    sequence s_lead;
        sck != pol && $past(sck) == pol;
    endsequence
    property p_dataOe;
        @(posedge linkClk) disable iff (rst) serialDataPinOe |-> serialClockPinOe;
    endproperty
    a_dataOe: assert property (p_dataOe) else $error("data without clock");
    property p_change;
        @(posedge linkClk) disable iff (rst) serialDataPinOe && $changed(sd) |-> sck != pol;
    endproperty
    a_change: assert property (p_change) else $error("data moved off lead");
    property p_stand;
        @(posedge linkClk) disable iff (rst) s_lead |=> $stable(sd);
    endproperty
    a_stand: assert property (p_stand) else $error("data moved early");
    // polarity is resynchronised, so allow a few link cycles after a change
    property p_pol1;
        @(posedge linkClk) disable iff (rst) pol && $past(pol, 6) && !sck |=> sck;
    endproperty
    a_pol1: assert property (p_pol1) else $error("clock low too long");
    property p_pol0;
        @(posedge linkClk) disable iff (rst) !pol && !$past(pol, 6) && sck |=> !sck;
    endproperty
    a_pol0: assert property (p_pol0) else $error("clock high too long");
    property p_load;
        @(posedge clk) disable iff (rst)
            holdWrite && !holdingFull |=> holdingFull && !transmitIrqFlag;
    endproperty
    a_load: assert property (p_load) else $error("write not taken");
    property p_full;
        @(posedge clk) disable iff (rst) holdWrite && holdingFull |=> writeIgnored;
    endproperty
    a_full: assert property (p_full) else $error("overwrite not flagged");
    property p_drain;
        @(posedge clk) disable iff (rst) $rose(holdingFull) && txOk |-> ##[1:40] !holdingFull;
    endproperty
    a_drain: assert property (p_drain) else $error("holding never moved");
endmodule : sync_tx_monitor

bind sync_serial_master_tx sync_tx_monitor mon (
    .clk(clk),
    .rst(rst),
    .linkClk(linkClk),
    .holdWrite(holdWrite),
    .clockPolaritySelect(clockPolaritySelect),
    .transmitEnable(transmitEnable),
    .singleReceiveEnable(singleReceiveEnable),
    .continuousReceiveEnable(continuousReceiveEnable),
    .serialDataPinOut(serialDataPinOut),
    .serialDataPinOe(serialDataPinOe),
    .serialClockPinOut(serialClockPinOut),
    .serialClockPinOe(serialClockPinOe),
    .transmitIrqFlag(transmitIrqFlag),
    .holdingFull(holdingFull),
    .writeIgnored(writeIgnored)
);

// ===== bench/tb_top.sv
`timescale 1ns/1ps

// ========
// bench top
module tb_top
    import sync_tx_pkg::*;
;
    logic clk = 1'h0;
    logic linkClk = 1'h0;
    logic rst = 1'h1;
    logic holdWrite = 1'h0;
    logic [DATA_W-1:0] holdWriteData = 8'h00;
    logic ninthBitSelect = 1'h0, ninthBitValue = 1'h0, clockPolaritySelect = 1'h0;
    logic clockedMode = 1'h0, portEnable = 1'h0, masterClockSource = 1'h0;
    logic transmitEnable = 1'h0, singleReceiveEnable = 1'h0, continuousReceiveEnable = 1'h0;
    logic serialDataPinOut, serialDataPinOe, serialClockPinOut, serialClockPinOe;
    logic transmitIrqFlag, holdingFull, shiftBusy, writeIgnored;
    // released line floats to the pull-up
    wire serialDataPinIn = serialDataPinOe ? serialDataPinOut : 1'h1;
    int mismatches = 0, total_checks = 0, i;
    // polarity, ninth select, ninth value, data | pulses, bits expected
    logic [23:0] rows [5] = '{
        {3'h1, 8'hA5, 4'h8, 9'h0A5},
        {3'h3, 8'h3C, 4'h9, 9'h13C},
        {3'h4, 8'h81, 4'h8, 9'h081},
        {3'h7, 8'h00, 4'h9, 9'h100},
        {3'h6, 8'hFF, 4'h9, 9'h0FF}
    };
    always #20 clk = ~clk;
    always #6 linkClk = ~linkClk;
    sync_serial_master_tx dut (
        .clk(clk),
        .rst(rst),
        .linkClk(linkClk),
        .holdWrite(holdWrite),
        .holdWriteData(holdWriteData),
        .ninthBitSelect(ninthBitSelect),
        .ninthBitValue(ninthBitValue),
        .clockPolaritySelect(clockPolaritySelect),
        .clockedMode(clockedMode),
        .portEnable(portEnable),
        .masterClockSource(masterClockSource),
        .transmitEnable(transmitEnable),
        .singleReceiveEnable(singleReceiveEnable),
        .continuousReceiveEnable(continuousReceiveEnable),
        .serialDataPinIn(serialDataPinIn),
        .serialDataPinOut(serialDataPinOut),
        .serialDataPinOe(serialDataPinOe),
        .serialClockPinOut(serialClockPinOut),
        .serialClockPinOe(serialClockPinOe),
        .transmitIrqFlag(transmitIrqFlag),
        .holdingFull(holdingFull),
        .shiftBusy(shiftBusy),
        .writeIgnored(writeIgnored)
    );
    // the slave sees the line itself, pull-up included
    slave_model m (
        .sck(serialClockPinOut),
        .sd(serialDataPinIn),
        .pol(clockPolaritySelect)
    );

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'h1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic put(input logic [9:0] w);
        step(1);
        {ninthBitSelect, ninthBitValue, holdWriteData} = w;
        holdWrite = 1'h1;
        step(1);
        holdWrite = 1'h0;
    endtask : put
    // extra idle cycles catch any surplus clock pulse
    task automatic expect_bits(input int n, input logic [17:0] e);
        int k;
        for (k = 0; k < 200 && m.bits.size() < n; k++) step(1);
        if (m.bits.size() < n) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, "bits never arrived");
            results();
        end
        step(10);
        chk(m.bits.size() == n, "pulse count");
        for (k = 0; k < n; k++) chk(m.bits[k] === e[k], "serial bit");
        m.bits.delete();
    endtask : expect_bits

    initial begin
        step(8);
        chk(transmitIrqFlag === 1'h1 && holdingFull === 1'h0, "reset flags");
        {clockedMode, portEnable, masterClockSource, transmitEnable} = 4'hF;
        step(8);
        rst = 1'h0;
        step(10);
        chk(serialClockPinOe === 1'h1 && serialDataPinOe === 1'h1, "pin enables");
        for (i = 0; i < 5; i++) begin
            clockPolaritySelect = rows[i][23];
            step(10);
            m.bits.delete();
            put(rows[i][22:13]);
            chk(holdingFull === 1'h1 && transmitIrqFlag === 1'h0, "write flags");
            expect_bits(int'(rows[i][12:9]), {9'h000, rows[i][8:0]});
            chk(transmitIrqFlag === 1'h1 && shiftBusy === 1'h0, "idle flags");
        end
        put(10'h0C3);
        put(10'h05A);
        chk(writeIgnored === 1'h1, "overwrite taken");
        expect_bits(8, 18'h000C3);
        put(10'h01E);
        for (i = 0; i < 50 && holdingFull !== 1'h0; i++) step(1);
        if (holdingFull !== 1'h0) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, "holding never emptied");
            results();
        end
        put(10'h0E7);
        chk(holdingFull === 1'h1 && shiftBusy === 1'h1, "no wait while shifting");
        expect_bits(16, 18'h0E71E);
        singleReceiveEnable = 1'h1;
        step(10);
        chk(serialDataPinOe === 1'h0 && serialClockPinOe === 1'h1, "receive enables");
        {singleReceiveEnable, continuousReceiveEnable} = 2'h1;
        put(10'h099);
        step(20);
        chk(m.bits.size() == 0 && serialDataPinOe === 1'h0, "sent while receiving");
        continuousReceiveEnable = 1'h0;
        expect_bits(8, 18'h00099);
        results();
    end
endmodule : tb_top

// ===== src/level_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser for slow levels and toggles
module level_sync
    import sync_tx_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule : level_sync

// ===== src/sync_serial_master_tx.sv
`timescale 1ns/1ps

// Summary of operation
// RQ1 - clock pin driven whenever clocked mode enabled; code drives it only with portEnable and masterClockSource also set
// RQ2 - data changes on leading clock edge
// RQ3 - exactly one clock per data bit
// RQ4 - polarity one: idle high, change on falling
// RQ5 - polarity zero: idle low, change on rising
// RQ6 - transmit drives data and clock pins
// RQ7 - holding register write alone starts transmission
// RQ8 - new character waits while shifter busy
// RQ9 - empty shifter loads holding register at once
// RQ10 - shifting starts right after the load
// RQ11 - bit valid from leading to next leading
// RQ12 - shift register hidden from the host
// RQ13 - host programs rate then mode bits
// RQ14 - host clears receive, sets transmit, loads
// RQ15 - ninth bit select and value sent last
// RQ16 - host sets interrupt enables for interrupts
// RQ17 - no start or stop bits framed
// RQ18 - half duplex: no transmit while receiving
// RQ19 - interrupt flag while holding register empty
// RQ20 - least significant bit first, ninth last
module sync_serial_master_tx
    import sync_tx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic holdWrite,
    input wire logic [DATA_W-1:0] holdWriteData,
    input wire logic ninthBitSelect,
    input wire logic ninthBitValue,
    input wire logic clockPolaritySelect,
    input wire logic clockedMode,
    input wire logic portEnable,
    input wire logic masterClockSource,
    input wire logic transmitEnable,
    input wire logic singleReceiveEnable,
    input wire logic continuousReceiveEnable,
    input wire logic serialDataPinIn,
    output logic serialDataPinOut,
    output logic serialDataPinOe,
    output logic serialClockPinOut,
    output logic serialClockPinOe,
    output logic transmitIrqFlag,
    output logic holdingFull,
    output logic shiftBusy,
    output logic writeIgnored
);

    // ==========================================
    // system clock domain: holding register
    logic [CHAR_W-1:0] holdChar_ff;
    logic [CHAR_W-1:0] nxt_holdChar;
    logic holdFull_ff;
    logic nxt_holdFull;
    logic reqTgl_ff;
    logic nxt_reqTgl;
    logic cfgClk_ff;
    logic nxt_cfgClk;
    logic cfgData_ff;
    logic nxt_cfgData;
    logic writeIgnored_ff;
    logic nxt_writeIgnored;
    logic ackSeen;
    logic busySeen;

    always_comb begin
        nxt_holdChar = holdChar_ff;
        nxt_holdFull = holdFull_ff;
        nxt_reqTgl = reqTgl_ff;
        nxt_writeIgnored = 1'h0;
        // pin enables decoded from the mode bits, registered, then synchronised to the link
        nxt_cfgClk = portEnable & clockedMode & masterClockSource; // RQ1
        nxt_cfgData = nxt_cfgClk & transmitEnable
            & ~singleReceiveEnable & ~continuousReceiveEnable; // RQ6 RQ18
        // link has taken the character: holding register free again
        if (holdFull_ff && (ackSeen == reqTgl_ff)) begin
            nxt_holdFull = 1'h0;
        end
        if (holdWrite) begin
            if (!holdFull_ff) begin
                nxt_holdChar[DATA_W-1:0] = holdWriteData; // RQ7
                nxt_holdChar[NINTH_POS] = ninthBitSelect & ninthBitValue; // RQ15
                nxt_holdChar = {nxt_holdChar[NINTH_POS], holdWriteData};
                nxt_holdFull = 1'h1; // RQ19
                nxt_reqTgl = ~reqTgl_ff; // RQ7
            end else begin
                // overwrite would corrupt the handshake data, so drop it
                nxt_writeIgnored = 1'h1;
            end
        end
    end

    logic ninthSel_ff;
    logic nxt_ninthSel;

    always_comb begin
        nxt_ninthSel = ninthSel_ff;
        if (holdWrite && !holdFull_ff) begin
            nxt_ninthSel = ninthBitSelect; // RQ15
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            holdChar_ff <= RST_CHAR;
            holdFull_ff <= 1'h0;
            reqTgl_ff <= RST_TOGGLE;
            cfgClk_ff <= 1'h0;
            cfgData_ff <= 1'h0;
            writeIgnored_ff <= 1'h0;
            ninthSel_ff <= 1'h0;
        end else begin
            holdChar_ff <= nxt_holdChar;
            holdFull_ff <= nxt_holdFull;
            reqTgl_ff <= nxt_reqTgl;
            cfgClk_ff <= nxt_cfgClk;
            cfgData_ff <= nxt_cfgData;
            writeIgnored_ff <= nxt_writeIgnored;
            ninthSel_ff <= nxt_ninthSel;
        end
    end

    assign transmitIrqFlag = ~holdFull_ff; // RQ19
    assign holdingFull = holdFull_ff;
    assign writeIgnored = writeIgnored_ff;

    // ==========================================
    // crossings
    logic [3:0] toLinkRaw;
    logic [3:0] toLink;
    logic [1:0] toClkRaw;
    logic [1:0] toClk;
    logic ackTgl_ff;
    logic busy_ff;

    assign toLinkRaw = {reqTgl_ff, cfgClk_ff, cfgData_ff, clockPolaritySelect};

    level_sync #(.WIDTH(4)) u_to_link (
        .clk(linkClk),
        .rst(rst),
        .din(toLinkRaw),
        .dout(toLink)
    );

    assign toClkRaw = {ackTgl_ff, busy_ff};

    level_sync #(.WIDTH(2)) u_to_clk (
        .clk(clk),
        .rst(rst),
        .din(toClkRaw),
        .dout(toClk)
    );

    assign ackSeen = toClk[1];
    assign busySeen = toClk[0];
    assign shiftBusy = busySeen;

    logic reqLink;
    logic clkOeLink;
    logic dataOeLink;
    logic polarityLink;

    assign reqLink = toLink[3];
    assign clkOeLink = toLink[2];
    assign dataOeLink = toLink[1];
    assign polarityLink = toLink[0];

    // ==========================================
    // link reset release
    // rst can drop at any phase of linkClk; leave reset on a link edge
    logic linkRunning;
    logic rstLink;

    level_sync #(.WIDTH(1)) u_link_reset (
        .clk(linkClk),
        .rst(rst),
        .din(1'h1),
        .dout(linkRunning)
    );

    assign rstLink = ~linkRunning;

    // ==========================================
    // link clock domain: hidden shift engine
    link_state_t state_ff;
    link_state_t nxt_state;
    logic [CHAR_W-1:0] shifter_ff;
    logic [CHAR_W-1:0] nxt_shifter;
    logic [BITCNT_W-1:0] bitsLeft_ff;
    logic [BITCNT_W-1:0] nxt_bitsLeft;
    logic phase_ff;
    logic nxt_phase;
    logic dataOut_ff;
    logic nxt_dataOut;
    logic nxt_ackTgl;
    logic nxt_busy;
    logic pendingChar;
    logic canLoad;
    logic loadChar;

    // holdChar_ff is held still from the request toggle until the ack returns
    assign pendingChar = reqLink ^ ackTgl_ff;
    assign canLoad = (state_ff == LINK_IDLE)
        || ((state_ff == LINK_TRAIL) && (bitsLeft_ff == RST_BITCNT)); // RQ8
    assign loadChar = pendingChar & canLoad & dataOeLink; // RQ9 RQ18

    always_comb begin
        nxt_state = state_ff;
        nxt_shifter = shifter_ff;
        nxt_bitsLeft = bitsLeft_ff;
        nxt_phase = phase_ff;
        nxt_dataOut = dataOut_ff;
        nxt_ackTgl = ackTgl_ff;
        unique case (state_ff)
            LINK_IDLE: begin
                nxt_phase = 1'h0;
            end
            LINK_LEAD: begin
                // trailing edge: back to idle level, data untouched
                nxt_phase = 1'h0; // RQ2 RQ11
                nxt_state = LINK_TRAIL;
            end
            LINK_TRAIL: begin
                if (bitsLeft_ff != RST_BITCNT) begin
                    // next leading edge carries the next bit
                    nxt_shifter = {1'h0, shifter_ff[CHAR_W-1:1]}; // RQ20
                    nxt_dataOut = shifter_ff[1]; // RQ2 RQ11
                    nxt_bitsLeft = bitsLeft_ff - 4'h1; // RQ3
                    nxt_phase = 1'h1;
                    nxt_state = LINK_LEAD;
                end else begin
                    // no extra clocks once the last bit is out
                    nxt_state = LINK_IDLE; // RQ3 RQ17
                end
            end
            default: begin
                nxt_state = LINK_IDLE;
                nxt_phase = 1'h0;
            end
        endcase
        if (loadChar) begin
            // first leading edge comes with the load itself
            nxt_shifter = holdChar_ff; // RQ9 RQ12
            nxt_dataOut = holdChar_ff[0]; // RQ20 RQ17
            nxt_bitsLeft = ninthSel_ff ? LAST_IDX_NINE : LAST_IDX_EIGHT; // RQ15
            nxt_phase = 1'h1; // RQ10
            nxt_state = LINK_LEAD; // RQ10
            nxt_ackTgl = ~ackTgl_ff;
        end
        nxt_busy = (nxt_state != LINK_IDLE);
    end

    always_ff @(posedge linkClk or posedge rstLink) begin
        if (rstLink) begin
            state_ff <= LINK_IDLE;
            shifter_ff <= RST_CHAR;
            bitsLeft_ff <= RST_BITCNT;
            phase_ff <= RST_PHASE;
            dataOut_ff <= RST_DATA_OUT;
            ackTgl_ff <= RST_TOGGLE;
            busy_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            shifter_ff <= nxt_shifter;
            bitsLeft_ff <= nxt_bitsLeft;
            phase_ff <= nxt_phase;
            dataOut_ff <= nxt_dataOut;
            ackTgl_ff <= nxt_ackTgl;
            busy_ff <= nxt_busy;
        end
    end

    // ==========================================
    // pins
    logic clkPin_ff;
    logic nxt_clkPin;
    logic clkOe_ff;
    logic nxt_clkOe;
    logic dataOe_ff;
    logic nxt_dataOe;

    // polarity flips the whole waveform; change it only while idle
    always_comb begin
        nxt_clkPin = nxt_phase ^ polarityLink; // RQ4 RQ5
        nxt_clkOe = clkOeLink; // RQ1
        nxt_dataOe = dataOeLink; // RQ6 RQ18
    end

    always_ff @(posedge linkClk or posedge rstLink) begin
        if (rstLink) begin
            clkPin_ff <= 1'h0;
            clkOe_ff <= 1'h0;
            dataOe_ff <= 1'h0;
        end else begin
            clkPin_ff <= nxt_clkPin;
            clkOe_ff <= nxt_clkOe;
            dataOe_ff <= nxt_dataOe;
        end
    end

    assign serialClockPinOut = clkPin_ff;
    assign serialClockPinOe = clkOe_ff;
    assign serialDataPinOut = dataOut_ff;
    assign serialDataPinOe = dataOe_ff;

endmodule : sync_serial_master_tx

// ===== src/sync_tx_pkg.sv
package sync_tx_pkg;

    // ==========================================
    // character layout
    localparam int DATA_W = 8;
    localparam int CHAR_W = 9;
    localparam int NINTH_POS = 8;
    localparam int BITCNT_W = 4;
    localparam logic [BITCNT_W-1:0] LAST_IDX_EIGHT = 4'h7;
    localparam logic [BITCNT_W-1:0] LAST_IDX_NINE = 4'h8;

    // ==========================================
    // link timing: link clock cycles per serial clock half period
    localparam int LINK_CYCLES_PER_HALF = 1;
    localparam int LINK_CYCLES_PER_BIT = 2 * LINK_CYCLES_PER_HALF;

    // ==========================================
    // reset values
    localparam logic RST_PHASE = 1'h0;
    localparam logic RST_DATA_OUT = 1'h0;
    localparam logic RST_TOGGLE = 1'h0;
    localparam logic [CHAR_W-1:0] RST_CHAR = 9'h000;
    localparam logic [BITCNT_W-1:0] RST_BITCNT = 4'h0;
    localparam int SYNC_STAGES = 2;

    // ==========================================
    // shift engine states
    typedef enum logic [2:0] {
        LINK_IDLE = 3'h1,
        LINK_LEAD = 3'h2,
        LINK_TRAIL = 3'h4
    } link_state_t;

endpackage : sync_tx_pkg
